// [verilog/hsq_homing_sequencer.sv]
// Homing sequencer with APB register file
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
module hsq_homing_sequencer #(
  parameter int MS_COUNT = hsq_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive inputs
  input wire logic drive_enable,
  input wire logic homing_start_in,
  input wire logic decel_point_in,
  input wire logic reference_switch_in,
  input wire logic limit_pos_in,
  input wire logic limit_neg_in,
  // Motion and status outputs
  output logic [11:0] motor_speed,
  output logic motor_dir,
  output logic homing_done_out,
  output logic electrical_homing_done_out,
  output logic homing_timeout_fault,
  output logic signed [31:0] absolute_position
);
  import hsq_pkg::*;

  // ------------------------------------------------------------
  // Registers and internal state
  // ------------------------------------------------------------
  logic [2:0] homing_trigger_mode;
  logic [1:0] offset_limit_handling;
  logic elec_select;
  logic [11:0] high_search_speed;
  logic [9:0] low_search_speed, homing_ramp_time;
  logic [15:0] homing_time_limit;
  logic signed [31:0] reference_offset;
  logic [2:0] switch_logic;
  hsq_state_t state;
  logic en_q, start_q, first_used;
  logic [11:0] target;
  logic [13:0] ramp_cnt, ramp_period, ms_div;
  logic [15:0] ms_elapsed;
  logic ms_tick;

  // Decoded events
  logic wr_en, setup, mapped, mode_wr;
  logic en_rise, start_rise, mode12, mode45, busy;
  logic ref_act, limit_hit, go, abort, timeout, here, complete;
  logic [31:0] rd_mux;

  assign wr_en = psel & penable & pready & pwrite;
  assign setup = psel & ~penable;
  assign mode_wr = wr_en & (paddr == ADDR_MODE);
  assign en_rise = drive_enable & ~en_q;
  assign start_rise = homing_start_in & ~start_q;
  assign mode12 = (homing_trigger_mode == TRIG_START1) | (homing_trigger_mode == TRIG_START2);
  assign mode45 = (homing_trigger_mode == TRIG_EN4) | (homing_trigger_mode == TRIG_EN5);
  assign busy = (state != HS_IDLE);
  // Edge settings map to a level: rising is high, falling and any edge low
  assign ref_act = (switch_logic == LOGIC_HIGH) || (switch_logic == LOGIC_RISE) ?
                   reference_switch_in : ~reference_switch_in;
  assign limit_hit = motor_dir ? limit_neg_in : limit_pos_in;
  // Start only from idle, so a repeated start while running is ignored
  assign go = ~busy & drive_enable & ((mode12 & start_rise)
              | ((homing_trigger_mode == TRIG_FIRST) & en_rise & ~first_used)
              | (mode45 & en_rise));
  assign abort = busy & (~drive_enable | (mode12 & ~homing_start_in));
  assign timeout = busy & ~abort & (ms_elapsed >= homing_time_limit);
  assign here = ~busy & (homing_trigger_mode == TRIG_HERE);
  assign complete = (state == HS_FINISH) & ~abort & ~timeout & (motor_speed == 12'h000);
  assign ms_tick = (ms_div == 14'(MS_COUNT - 1));
  assign ramp_period = 14'({4'h0, homing_ramp_time} * 14'(US_CYCLES));

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // Read data mux; unmapped words read as zero
  always_comb begin
    mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_SPEED);
    case (paddr)
      ADDR_MODE: rd_mux = {23'h0, elec_select, 2'h0, offset_limit_handling, 1'b0,
                           homing_trigger_mode};
      ADDR_HIGH: rd_mux = {20'h0, high_search_speed};
      ADDR_LOW: rd_mux = {22'h0, low_search_speed};
      ADDR_RAMP: rd_mux = {22'h0, homing_ramp_time};
      ADDR_LIMIT: rd_mux = {16'h0, homing_time_limit};
      ADDR_OFFSET: rd_mux = reference_offset;
      ADDR_LOGIC: rd_mux = {29'h0, switch_logic};
      ADDR_STATUS: rd_mux = {25'h0, first_used, motor_dir, electrical_homing_done_out,
                             homing_done_out, homing_timeout_fault, state};
      ADDR_ABS: rd_mux = absolute_position;
      ADDR_SPEED: rd_mux = {20'h0, motor_speed};
      default: rd_mux = 32'h0;
    endcase
  end

  // No wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= rd_mux;
      end
    end
  end

  // Setting registers; out-of-range speed, ramp and offset writes saturate at the documented bound
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_limit_handling <= RST_HANDLE;
      elec_select <= 1'b0;
      high_search_speed <= RST_HIGH;
      low_search_speed <= RST_LOW;
      homing_ramp_time <= RST_RAMP;
      homing_time_limit <= RST_LIMIT;
      reference_offset <= RST_OFFSET;
      switch_logic <= RST_LOGIC;
    end else if (wr_en) begin
      case (paddr)
        ADDR_MODE: begin
          offset_limit_handling <= pwdata[MODE_HANDLE_LSB +: 2];
          elec_select <= pwdata[MODE_ELEC_BIT];
        end
        ADDR_HIGH: high_search_speed <= (pwdata > 32'(MAX_HIGH)) ? MAX_HIGH : pwdata[11:0];
        ADDR_LOW: low_search_speed <= (pwdata > 32'(MAX_LOW)) ? MAX_LOW : pwdata[9:0];
        ADDR_RAMP: homing_ramp_time <= (pwdata > 32'(MAX_RAMP)) ? MAX_RAMP : pwdata[9:0];
        ADDR_LIMIT: homing_time_limit <= pwdata[15:0];
        ADDR_OFFSET: reference_offset <= ($signed(pwdata) > OFFSET_MAX) ? OFFSET_MAX :
          ($signed(pwdata) < OFFSET_MIN) ? OFFSET_MIN : $signed(pwdata);
        ADDR_LOGIC: switch_logic <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Trigger mode; a software write in the same cycle beats the hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      homing_trigger_mode <= RST_TRIG;
    end else if (mode_wr) begin
      homing_trigger_mode <= pwdata[MODE_TRIG_LSB +: 3];
    end else if (here | (mode45 & (timeout | complete))) begin
      homing_trigger_mode <= TRIG_OFF;
    end
  end

  // ------------------------------------------------------------
  // Input history and power-up latch
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      start_q <= 1'b0;
      first_used <= 1'b0;
    end else begin
      en_q <= drive_enable;
      start_q <= homing_start_in;
      // Any first enable uses up the one-shot, only a reset rearms it
      first_used <= first_used | en_rise;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Stop and timeout take priority over every search step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HS_IDLE;
      motor_dir <= 1'b0;
    end else begin
      case (state)
        HS_IDLE: begin
          if (go) begin
            state <= HS_FAST;
            motor_dir <= 1'b0;
          end
        end
        HS_FAST: begin
          if (abort | timeout) begin
            state <= HS_IDLE;
          end else if (limit_hit) begin
            motor_dir <= ~motor_dir;
          end else if (elec_select & ref_act) begin
            state <= HS_FINISH;
          end else if (~elec_select & decel_point_in) begin
            state <= HS_SLOW;
          end
        end
        HS_SLOW: begin
          if (abort | timeout) begin
            state <= HS_IDLE;
          end else if (ref_act) begin
            state <= HS_FINISH;
          end else if (limit_hit) begin
            motor_dir <= ~motor_dir;
            state <= HS_FAST;
          end
        end
        HS_FINISH: begin
          if (abort | timeout | complete) begin
            state <= HS_IDLE;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // Speed target per phase
  always_comb begin
    case (state)
      HS_FAST: target = high_search_speed;
      HS_SLOW: target = {2'h0, low_search_speed};
      default: target = 12'h000;
    endcase
  end

  // Linear ramp, one rpm per ramp period; zero ramp time jumps at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_speed <= 12'h000;
      ramp_cnt <= 14'h0000;
    end else if (motor_speed == target) begin
      ramp_cnt <= 14'h0000;
    end else if (homing_ramp_time == 10'h000) begin
      motor_speed <= target;
    end else if (ramp_cnt >= ramp_period - 14'h0001) begin
      ramp_cnt <= 14'h0000;
      motor_speed <= (motor_speed < target) ? motor_speed + 12'h001 :
                     motor_speed - 12'h001;
    end else begin
      ramp_cnt <= ramp_cnt + 14'h0001;
    end
  end

  // Millisecond watchdog over the whole sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div <= 14'h0000;
      ms_elapsed <= 16'h0000;
    end else if (go | ~busy) begin
      ms_div <= 14'h0000;
      ms_elapsed <= 16'h0000;
    end else if (ms_tick) begin
      ms_div <= 14'h0000;
      // Saturates instead of wrapping back under the limit
      ms_elapsed <= ms_elapsed + {15'h0000, ms_elapsed != 16'hffff};
    end else begin
      ms_div <= ms_div + 14'h0001;
    end
  end

  // Timeout fault; a new timeout wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      homing_timeout_fault <= 1'b0;
    end else if (timeout) begin
      homing_timeout_fault <= 1'b1;
    end else if (mode12 & start_rise & drive_enable) begin
      homing_timeout_fault <= 1'b0;
    end else if (~mode12 & ~drive_enable) begin
      homing_timeout_fault <= 1'b0;
    end
  end

  // Completion flags and position load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      homing_done_out <= 1'b0;
      electrical_homing_done_out <= 1'b0;
      absolute_position <= 32'sh00000000;
    end else if (go) begin
      homing_done_out <= 1'b0;
      electrical_homing_done_out <= 1'b0;
    end else if (here | complete) begin
      // Relative handling adds the offset; coordinate handling replaces the position
      absolute_position <= (offset_limit_handling == 2'h1) ?
                           absolute_position + reference_offset : reference_offset;
      homing_done_out <= here | ~elec_select;
      electrical_homing_done_out <= complete & elec_select;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_timeout_fault: assert property (@(posedge pclk) disable iff (!presetn)
    timeout |=> homing_timeout_fault && state == HS_IDLE)
    else $error("timeout did not raise fault and stop");
  a_enable_stop: assert property (@(posedge pclk) disable iff (!presetn)
    busy && !drive_enable |=> state == HS_IDLE ##1 target == 12'h000)
    else $error("enable drop did not stop homing");
  a_rerun_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !busy && mode12 && start_rise && drive_enable |=> !homing_timeout_fault && busy)
    else $error("restart did not clear fault and rerun");
  a_first_only: assert property (@(posedge pclk) disable iff (!presetn)
    !busy && homing_trigger_mode == TRIG_FIRST && first_used |=> !busy)
    else $error("mode 3 homed twice");
  a_mode_clear: assert property (@(posedge pclk) disable iff (!presetn)
    mode45 && (timeout || complete) && !mode_wr |=> homing_trigger_mode == TRIG_OFF)
    else $error("modes 4-5 not cleared");
  a_here_load: assert property (@(posedge pclk) disable iff (!presetn)
    here && !mode_wr && offset_limit_handling != 2'h1 |=>
    absolute_position == $past(reference_offset) && homing_done_out &&
    homing_trigger_mode == TRIG_OFF)
    else $error("mode 6 load or clear wrong");
  a_slow_target: assert property (@(posedge pclk) disable iff (!presetn)
    state == HS_SLOW && $past(state) == HS_SLOW && homing_ramp_time == 10'h000 &&
    $stable(homing_ramp_time) && $stable(low_search_speed) |->
    motor_speed == {2'h0, low_search_speed})
    else $error("slow phase speed wrong");
  a_ramp_step: assert property (@(posedge pclk) disable iff (!presetn)
    homing_ramp_time != 10'h000 && $stable(homing_ramp_time) |=>
    motor_speed == $past(motor_speed) || motor_speed == $past(motor_speed) + 12'h001 ||
    motor_speed + 12'h001 == $past(motor_speed))
    else $error("ramp stepped more than one rpm");
  a_switch_stop: assert property (@(posedge pclk) disable iff (!presetn)
    state == HS_SLOW && ref_act && !abort && !timeout |=> state == HS_FINISH)
    else $error("switch did not end the search");
  a_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
    go |=> !homing_done_out && !electrical_homing_done_out)
    else $error("done flags not cleared at start");
endmodule

// [include/hsq_pkg.sv]
// Constants, register map and types of the homing sequencer
package hsq_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int MS_PER_S = 1_000;
  localparam int US_CYCLES = CLK_HZ / US_PER_S;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_HIGH = 8'h04;
  localparam logic [7:0] ADDR_LOW = 8'h08;
  localparam logic [7:0] ADDR_RAMP = 8'h0c;
  localparam logic [7:0] ADDR_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_OFFSET = 8'h14;
  localparam logic [7:0] ADDR_LOGIC = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_ABS = 8'h20;
  localparam logic [7:0] ADDR_SPEED = 8'h24;
  // ------------------------------------------------------------
  // Field positions of the mode register
  // ------------------------------------------------------------
  localparam int MODE_TRIG_LSB = 0;
  localparam int MODE_HANDLE_LSB = 4;
  localparam int MODE_ELEC_BIT = 8;
  // ------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------
  localparam logic [2:0] RST_TRIG = 3'h0;
  localparam logic [1:0] RST_HANDLE = 2'h0;
  localparam logic [11:0] RST_HIGH = 12'h064;
  localparam logic [11:0] MAX_HIGH = 12'hbb8;
  localparam logic [9:0] RST_LOW = 10'h00a;
  localparam logic [9:0] MAX_LOW = 10'h3e8;
  localparam logic [9:0] RST_RAMP = 10'h3e8;
  localparam logic [9:0] MAX_RAMP = 10'h3e8;
  localparam logic [15:0] RST_LIMIT = 16'h2710;
  localparam logic signed [31:0] RST_OFFSET = 32'sh00000000;
  localparam logic signed [31:0] OFFSET_MAX = 32'sh40000000;
  localparam logic signed [31:0] OFFSET_MIN = -32'sh40000000;
  localparam logic [2:0] RST_LOGIC = 3'h0;
  // ------------------------------------------------------------
  // Trigger modes and switch logic codes
  // ------------------------------------------------------------
  localparam logic [2:0] TRIG_OFF = 3'h0;
  localparam logic [2:0] TRIG_START1 = 3'h1;
  localparam logic [2:0] TRIG_START2 = 3'h2;
  localparam logic [2:0] TRIG_FIRST = 3'h3;
  localparam logic [2:0] TRIG_EN4 = 3'h4;
  localparam logic [2:0] TRIG_EN5 = 3'h5;
  localparam logic [2:0] TRIG_HERE = 3'h6;
  localparam logic [2:0] LOGIC_HIGH = 3'h1;
  localparam logic [2:0] LOGIC_RISE = 3'h3;
  typedef enum logic [1:0] {HS_IDLE, HS_FAST, HS_SLOW, HS_FINISH} hsq_state_t;
endpackage

// [dv/hsq_host_model.sv]
// Host controller model driving servo enable and homing start
`timescale 1ns/100ps
module hsq_host_model (
  // Clock
  input wire logic pclk,
  // Host outputs
  output logic drive_enable,
  output logic homing_start_in
);
  // Both lines idle inactive from time zero
  logic en_r = 1'b0;
  logic start_r = 1'b0;
  assign drive_enable = en_r;
  assign homing_start_in = start_r;
  // Servo enable, changed just after a rising edge
  task automatic set_enable(input logic v);
    @(posedge pclk);
    en_r <= v;
  endtask
  // Start line; a start never goes out ahead of the enable
  task automatic set_start(input logic v);
    if (v && drive_enable !== 1'b1) begin
      set_enable(1'b1);
    end
    @(posedge pclk);
    start_r <= v;
  endtask
endmodule

// [dv/tb_homing_sequencer.sv]
// Self-checking testbench of the homing sequencer
`timescale 1ns/100ps
module tb_homing_sequencer;
  import hsq_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic drive_enable, homing_start_in, decel, ref_sw, lim_p, lim_n;
  logic [11:0] motor_speed;
  logic motor_dir, done, edone, fault;
  logic signed [31:0] abs_pos;
  int fails, total_checks;
  int cycles = 0;
  // Short millisecond keeps timeouts inside a brief run
  hsq_homing_sequencer #(
    .MS_COUNT(10)
  ) dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .drive_enable(drive_enable),
    .homing_start_in(homing_start_in),
    .decel_point_in(decel),
    .reference_switch_in(ref_sw),
    .limit_pos_in(lim_p),
    .limit_neg_in(lim_n),
    .motor_speed(motor_speed),
    .motor_dir(motor_dir),
    .homing_done_out(done),
    .electrical_homing_done_out(edone),
    .homing_timeout_fault(fault),
    .absolute_position(abs_pos)
  );
  hsq_host_model host (
    .pclk(pclk),
    .drive_enable(drive_enable),
    .homing_start_in(homing_start_in)
  );
  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Cycle count for the watchdog in the main sequence
  always @(posedge pclk) begin
    cycles <= cycles + 1;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task finish_test();
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  // Bounded waits on speed and on a status flag (0 done, 1 elec, 2 fault)
  task wspd(input logic [11:0] x);
    int n;
    n = 0;
    while (motor_speed !== x && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check({20'h0, motor_speed}, {20'h0, x});
  endtask
  task wflag(input int k, input logic x);
    int n;
    logic v;
    n = 0;
    v = (k == 0) ? done : (k == 1) ? edone : fault;
    while (v !== x && n < 200) begin
      @(posedge pclk);
      n++;
      v = (k == 0) ? done : (k == 1) ? edone : fault;
    end
    check({31'h0, v}, {31'h0, x});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs();
    rd(ADDR_HIGH, 32'd100, 1'b0);
    rd(ADDR_LOW, 32'd10, 1'b0);
    rd(ADDR_RAMP, 32'd1000, 1'b0);
    rd(ADDR_LIMIT, 32'd10000, 1'b0);
    rd(ADDR_OFFSET, 32'h0, 1'b0);
    rd(ADDR_LOGIC, 32'h0, 1'b0);
    wr(ADDR_HIGH, 32'd4000);
    rd(ADDR_HIGH, 32'd3000, 1'b0);
    wr(ADDR_HIGH, 32'd100);
    wr(ADDR_OFFSET, 32'h7fffffff);
    rd(ADDR_OFFSET, 32'h40000000, 1'b0);
    wr(ADDR_OFFSET, 32'h80000000);
    rd(ADDR_OFFSET, 32'hc0000000, 1'b0);
    rd(8'h28, 32'h0, 1'b1);
    rd(8'hc2, 32'h0, 1'b1);
  endtask
  // Start-driven homing, limit reversal, rerun and both aborts
  task t_mode1();
    wr(ADDR_RAMP, 32'h0);
    wr(ADDR_LOGIC, 32'h1);
    wr(ADDR_OFFSET, 32'hfffffffb);
    wr(ADDR_MODE, 32'h1);
    host.set_start(1'b1);
    wspd(12'd100);
    @(posedge pclk);
    decel <= 1'b1;
    wspd(12'd10);
    @(posedge pclk);
    decel <= 1'b0;
    lim_p <= 1'b1;
    @(posedge pclk);
    lim_p <= 1'b0;
    wspd(12'd100);
    check({31'h0, motor_dir}, 32'h1);
    @(posedge pclk);
    lim_n <= 1'b1;
    @(posedge pclk);
    lim_n <= 1'b0;
    @(posedge pclk);
    check({31'h0, motor_dir}, 32'h0);
    @(posedge pclk);
    decel <= 1'b1;
    wspd(12'd10);
    @(posedge pclk);
    ref_sw <= 1'b1;
    wflag(0, 1'b1);
    check(abs_pos, 32'hfffffffb);
    check({31'h0, edone}, 32'h0);
    @(posedge pclk);
    decel <= 1'b0;
    ref_sw <= 1'b0;
    host.set_start(1'b0);
    host.set_start(1'b1);
    wspd(12'd100);
    check({31'h0, done}, 32'h0);
    host.set_start(1'b0);
    wspd(12'd0);
    host.set_start(1'b1);
    wspd(12'd100);
    host.set_enable(1'b0);
    wspd(12'd0);
    check({31'h0, done}, 32'h0);
  endtask
  task t_timeout();
    host.set_start(1'b0);
    wr(ADDR_LIMIT, 32'd2);
    wr(ADDR_MODE, 32'h2);
    host.set_start(1'b1);
    wflag(2, 1'b1);
    wspd(12'd0);
    host.set_start(1'b0);
    host.set_start(1'b1);
    repeat (2) @(posedge pclk);
    check({31'h0, fault}, 32'h0);
    wspd(12'd100);
    host.set_start(1'b0);
    wr(ADDR_LIMIT, 32'd10000);
  endtask
  task t_elec();
    wr(ADDR_MODE, 32'h101);
    host.set_start(1'b1);
    wspd(12'd100);
    @(posedge pclk);
    ref_sw <= 1'b1;
    wflag(1, 1'b1);
    check({31'h0, done}, 32'h0);
    @(posedge pclk);
    ref_sw <= 1'b0;
    host.set_start(1'b0);
  endtask
  // One millisecond per 1000 rpm gives one rpm per ten cycles
  task t_ramp();
    logic [11:0] s;
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_RAMP, 32'h1);
    host.set_start(1'b1);
    repeat (300) @(posedge pclk);
    s = motor_speed;
    check({31'h0, s >= 12'd25 && s <= 12'd35}, 32'h1);
    host.set_start(1'b0);
    wr(ADDR_RAMP, 32'h0);
  endtask
  task t_mode6();
    wr(ADDR_OFFSET, 32'd1234);
    wr(ADDR_MODE, 32'h6);
    wflag(0, 1'b1);
    check(abs_pos, 32'd1234);
    rd(ADDR_MODE, 32'h0, 1'b0);
    // Relative handling adds the offset to the present position
    wr(ADDR_OFFSET, 32'd10);
    wr(ADDR_MODE, 32'h16);
    repeat (2) @(posedge pclk);
    check(abs_pos, 32'd1244);
  endtask
  // Power-up again so the first enable is really the first
  task t_mode3();
    host.set_enable(1'b0);
    do_reset();
    wr(ADDR_RAMP, 32'h0);
    wr(ADDR_LOGIC, 32'h1);
    wr(ADDR_LIMIT, 32'd2);
    wr(ADDR_MODE, 32'h3);
    host.set_enable(1'b1);
    wspd(12'd100);
    wflag(2, 1'b1);
    wspd(12'd0);
    host.set_enable(1'b0);
    wflag(2, 1'b0);
    host.set_enable(1'b1);
    repeat (30) @(posedge pclk);
    check({20'h0, motor_speed}, 32'h0);
    rd(ADDR_STATUS, 32'h40, 1'b0);
  endtask
  // Enable-driven homing with a low-active switch
  task t_mode4();
    wr(ADDR_LIMIT, 32'd10000);
    wr(ADDR_LOGIC, 32'h0);
    wr(ADDR_MODE, 32'h4);
    @(posedge pclk);
    ref_sw <= 1'b1;
    host.set_enable(1'b0);
    host.set_enable(1'b1);
    wspd(12'd100);
    host.set_enable(1'b0);
    wspd(12'd0);
    host.set_enable(1'b1);
    wspd(12'd100);
    @(posedge pclk);
    decel <= 1'b1;
    wspd(12'd10);
    @(posedge pclk);
    ref_sw <= 1'b0;
    wflag(0, 1'b1);
    rd(ADDR_MODE, 32'h0, 1'b0);
    // Mode 5 with a rising-edge setting, which acts as high active
    wr(ADDR_LOGIC, 32'h3);
    wr(ADDR_MODE, 32'h5);
    host.set_enable(1'b0);
    host.set_enable(1'b1);
    wspd(12'd10);
    @(posedge pclk);
    ref_sw <= 1'b1;
    wflag(0, 1'b1);
    rd(ADDR_MODE, 32'h0, 1'b0);
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {decel, ref_sw, lim_p, lim_n} = '0;
    fails = 0;
    total_checks = 0;
    do_reset();
    // Whichever ends first, the scenarios or the watchdog, leads to the verdict
    fork
      begin
        t_regs();
        t_mode1();
        t_timeout();
        t_elec();
        t_ramp();
        t_mode6();
        t_mode3();
        t_mode4();
      end
      begin
        wait (cycles >= 30000);
        fails++;
      end
    join_any
    finish_test();
  end
endmodule
